//--- logic/rbm_regs.svh
// Purpose: constants for the receive buffer manager
// Assumes: byte addresses, 16-bit descriptor fields
// Notes:   offsets and steps used by rbm_rx_buffer_manager
`ifndef RBM_REGS_SVH
`define RBM_REGS_SVH

// ************************************************************
// address steps
// ************************************************************
`define RBM_FIELD_STEP16 16'h0002
`define RBM_FIELD_STEP32 16'h0004
`define RBM_RING_STEP16  16'h0008
`define RBM_RING_STEP32  16'h0010
`define RBM_DESC_STEP16  16'h000C
`define RBM_DESC_STEP32  16'h0018
`define RBM_DATA_STEP16  32'h0000_0002
`define RBM_DATA_STEP32  32'h0000_0004

// ************************************************************
// word counts, field indices and reset values
// ************************************************************
`define RBM_WC_DEC16     32'h0000_0001
`define RBM_WC_DEC32     32'h0000_0002
`define RBM_FLD_FIRST    2'h0
`define RBM_FLD_PTR_HI   2'h1
`define RBM_FLD_WC_LO    2'h2
`define RBM_FLD_LAST     2'h3
`define RBM_HALF_ZERO    16'h0000
`define RBM_RESET_ADDR   32'h0000_0000
`define RBM_RESET_OFF    16'h0000

`endif

//--- logic/rbm_pkg.sv
// Purpose: shared types of the receive buffer manager
// Assumes: nothing beyond SystemVerilog
// Notes:   constants live in rbm_regs.svh
package rbm_pkg;
	// controller states
	typedef enum logic [2:0] {
		RBM_IDLE,
		RBM_FETCH,
		RBM_RX,
		RBM_DROP,
		RBM_DESC,
		RBM_CHECK
	} rbm_state_t;
endpackage

//--- logic/rbm_field_join.sv
// Purpose: joins 16-bit ring entry fields into 32-bit values
// Assumes: fields arrive in order ptr lo, ptr hi, count lo, count hi
// Notes:   outputs registered
`timescale 1ns/1ps
`default_nettype none
`include "rbm_regs.svh"

module rbm_field_join
	import rbm_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        load_i,
	input  wire logic [1:0]  index_i,
	input  wire logic [15:0] half_i,
	output logic      [31:0] ptr_o,
	output logic      [31:0] count_o
);

	// ************************************************************
	// field capture
	// ************************************************************
	// place each half at its position in the long values
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ptr_o   <= `RBM_RESET_ADDR;
			count_o <= `RBM_RESET_ADDR;
		end else if (load_i) begin
			unique case (index_i)
				`RBM_FLD_FIRST:  ptr_o[15:0]    <= half_i;
				`RBM_FLD_PTR_HI: ptr_o[31:16]   <= half_i;
				`RBM_FLD_WC_LO:  count_o[15:0]  <= half_i;
				`RBM_FLD_LAST:   count_o[31:16] <= half_i;
			endcase
		end
	end

endmodule
`default_nettype wire

//--- logic/rbm_rx_buffer_manager.sv
// Purpose: receive buffer manager of an ethernet dma engine
// Assumes: one memory request outstanding, ack completes it
// Notes:   descriptor link and in-use handling are elsewhere
`timescale 1ns/1ps
`default_nettype none
`include "rbm_regs.svh"

module rbm_rx_buffer_manager
	import rbm_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        mode32_i,
	input  wire logic        receiver_enable_i,
	input  wire logic        ring_fetch_command_i,
	input  wire logic [15:0] ring_upper_base_i,
	input  wire logic [15:0] ring_start_pointer_i,
	input  wire logic [15:0] ring_end_pointer_i,
	input  wire logic [15:0] ring_write_pointer_i,
	input  wire logic        ring_read_load_i,
	input  wire logic [15:0] ring_read_value_i,
	input  wire logic [15:0] desc_upper_base_i,
	input  wire logic        desc_load_i,
	input  wire logic [15:0] desc_value_i,
	input  wire logic [15:0] end_margin_count_i,
	input  wire logic        overrun_clear_i,
	input  wire logic        pkt_valid_i,
	input  wire logic [31:0] pkt_data_i,
	input  wire logic        pkt_last_i,
	input  wire logic        match_phys_i,
	input  wire logic        match_mcast_i,
	input  wire logic        match_bcast_i,
	input  wire logic [15:0] pkt_status_i,
	input  wire logic [15:0] pkt_byte_count_i,
	output logic             pkt_ready_o,
	output logic             mem_req_o,
	output logic             mem_we_o,
	output logic      [31:0] mem_addr_o,
	output logic      [31:0] mem_wdata_o,
	input  wire logic        mem_ack_i,
	input  wire logic [31:0] mem_rdata_i,
	output logic             ring_fetch_command_o,
	output logic             buffer_overrun_flag_o,
	output logic             ring_empty_o,
	output logic      [15:0] ring_read_pointer_o,
	output logic      [15:0] desc_pointer_o,
	output logic      [31:0] current_buffer_address_o,
	output logic      [31:0] remaining_word_count_o
);

	// ************************************************************
	// state and derived terms
	// ************************************************************
	rbm_state_t  state_reg;
	logic        mem_req_reg;
	logic        mem_we_reg;
	logic [31:0] mem_addr_reg;
	logic [31:0] mem_wdata_reg;
	logic [1:0]  fld_reg;
	logic [15:0] rrp_reg;
	logic [15:0] desc_off_reg;
	logic [31:0] cur_addr_reg;
	logic [31:0] rwc_reg;
	logic [31:0] pkt_addr_reg;
	logic [15:0] status_reg;
	logic [15:0] bytes_reg;
	logic        last_seen_reg;
	logic        cmd_reg;
	logic        by_cmd_reg;
	logic        overrun_reg;
	logic [31:0] join_ptr;
	logic [31:0] join_count;
	logic [15:0] field_step;
	logic [15:0] ring_step;
	logic [15:0] desc_step;
	logic [31:0] data_step;
	logic [31:0] wc_step;
	logic [15:0] rrp_next;
	logic        mem_done;
	logic        fetch_done;
	logic        desc_done;
	logic        beat;
	logic        fits;
	logic        store_beat;
	logic        below_margin;

	// per-mode steps
	assign field_step   = mode32_i ? `RBM_FIELD_STEP32 : `RBM_FIELD_STEP16;
	assign ring_step    = mode32_i ? `RBM_RING_STEP32 : `RBM_RING_STEP16;
	assign desc_step    = mode32_i ? `RBM_DESC_STEP32 : `RBM_DESC_STEP16;
	assign data_step    = mode32_i ? `RBM_DATA_STEP32 : `RBM_DATA_STEP16;
	assign wc_step      = mode32_i ? `RBM_WC_DEC32 : `RBM_WC_DEC16;
	assign mem_done     = mem_req_reg && mem_ack_i;
	assign fetch_done   = (state_reg == RBM_FETCH) && mem_done && (fld_reg == `RBM_FLD_LAST);
	assign desc_done    = (state_reg == RBM_DESC) && mem_done && (fld_reg == `RBM_FLD_LAST);
	assign pkt_ready_o  = (state_reg == RBM_DROP) ||
	                      ((state_reg == RBM_RX) && !mem_req_reg && !last_seen_reg);
	assign beat         = (state_reg == RBM_RX) && pkt_valid_i && pkt_ready_o;
	assign fits         = rwc_reg >= wc_step;
	assign store_beat   = beat && fits;
	assign below_margin = rwc_reg < {`RBM_HALF_ZERO, end_margin_count_i};
	assign rrp_next     = ((rrp_reg + ring_step) >= ring_end_pointer_i) ? ring_start_pointer_i
	                      : rrp_reg + ring_step;

	// ************************************************************
	// entry joiner
	// ************************************************************
	// halves joined into long values
	rbm_field_join u_join (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.load_i    ((state_reg == RBM_FETCH) && mem_done),
		.index_i   (fld_reg),
		.half_i    (mem_rdata_i[15:0]),
		.ptr_o     (join_ptr),
		.count_o   (join_count)
	);

	// ************************************************************
	// controller and memory requests
	// ************************************************************
	// sequencing of fetch, store, descriptor write and margin check
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg     <= RBM_IDLE;
			mem_req_reg   <= 1'b0;
			mem_we_reg    <= 1'b0;
			mem_addr_reg  <= `RBM_RESET_ADDR;
			mem_wdata_reg <= `RBM_RESET_ADDR;
			fld_reg       <= `RBM_FLD_FIRST;
			last_seen_reg <= 1'b0;
			by_cmd_reg    <= 1'b0;
			pkt_addr_reg  <= `RBM_RESET_ADDR;
			status_reg    <= `RBM_HALF_ZERO;
			bytes_reg     <= `RBM_HALF_ZERO;
		end else begin
			if (mem_done) begin
				mem_req_reg <= 1'b0;
			end
			unique case (state_reg)
				RBM_IDLE: begin
					if (cmd_reg) begin
						state_reg    <= RBM_FETCH;
						by_cmd_reg   <= 1'b1;
						mem_req_reg  <= 1'b1;
						mem_we_reg   <= 1'b0;
						fld_reg      <= `RBM_FLD_FIRST;
						mem_addr_reg <= {ring_upper_base_i, rrp_reg};
					end else if (receiver_enable_i && pkt_valid_i) begin
						if (match_phys_i || match_mcast_i || match_bcast_i) begin
							state_reg     <= RBM_RX;
							pkt_addr_reg  <= cur_addr_reg;
							last_seen_reg <= 1'b0;
						end else begin
							state_reg <= RBM_DROP;
						end
					end
				end
				RBM_DROP: begin
					if (pkt_valid_i && pkt_last_i) begin
						state_reg <= RBM_IDLE;
					end
				end
				RBM_RX: begin
					if (store_beat) begin
						mem_req_reg   <= 1'b1;
						mem_we_reg    <= 1'b1;
						mem_addr_reg  <= cur_addr_reg;
						mem_wdata_reg <= mode32_i ? pkt_data_i : {16'h0000, pkt_data_i[15:0]};
					end
					if (beat && pkt_last_i) begin
						last_seen_reg <= 1'b1;
						status_reg    <= pkt_status_i;
						bytes_reg     <= pkt_byte_count_i;
					end
					if (last_seen_reg && !mem_req_reg) begin
						state_reg     <= RBM_DESC;
						mem_req_reg   <= 1'b1;
						mem_we_reg    <= 1'b1;
						fld_reg       <= `RBM_FLD_FIRST;
						mem_addr_reg  <= {desc_upper_base_i, desc_off_reg};
						mem_wdata_reg <= {16'h0000, status_reg};
					end
				end
				RBM_DESC: begin
					if (mem_done) begin
						if (fld_reg == `RBM_FLD_LAST) begin
							state_reg <= RBM_CHECK;
						end else begin
							mem_req_reg  <= 1'b1;
							fld_reg      <= fld_reg + 2'h1;
							mem_addr_reg <= {desc_upper_base_i,
							                 16'(desc_off_reg + field_step * {14'h0000, fld_reg + 2'h1})};
							unique case (fld_reg)
								`RBM_FLD_FIRST:  mem_wdata_reg <= {16'h0000, bytes_reg};
								`RBM_FLD_PTR_HI: mem_wdata_reg <= {16'h0000, pkt_addr_reg[15:0]};
								default:         mem_wdata_reg <= {16'h0000, pkt_addr_reg[31:16]};
							endcase
						end
					end
				end
				RBM_CHECK: begin
					// margin crossing selects a new buffer
					if (below_margin) begin
						state_reg    <= RBM_FETCH;
						by_cmd_reg   <= 1'b0;
						mem_req_reg  <= 1'b1;
						mem_we_reg   <= 1'b0;
						fld_reg      <= `RBM_FLD_FIRST;
						mem_addr_reg <= {ring_upper_base_i, rrp_reg};
					end else begin
						state_reg <= RBM_IDLE;
					end
				end
				RBM_FETCH: begin
					if (mem_done) begin
						if (fld_reg == `RBM_FLD_LAST) begin
							state_reg <= RBM_IDLE;
						end else begin
							// ring address upper base over read pointer
							mem_req_reg  <= 1'b1;
							mem_we_reg   <= 1'b0;
							fld_reg      <= fld_reg + 2'h1;
							mem_addr_reg <= {ring_upper_base_i,
							                 16'(rrp_reg + field_step * {14'h0000, fld_reg + 2'h1})};
						end
					end
				end
			endcase
		end
	end

	// ************************************************************
	// ring read pointer
	// ************************************************************
	// device side of the circular ring
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rrp_reg <= `RBM_RESET_OFF;
		end else if (fetch_done) begin
			rrp_reg <= rrp_next;
		end else if (ring_read_load_i) begin
			rrp_reg <= ring_read_value_i;
		end
	end

	// ************************************************************
	// descriptor pointer
	// ************************************************************
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			desc_off_reg <= `RBM_RESET_OFF;
		end else if (desc_done) begin
			desc_off_reg <= desc_off_reg + desc_step;
		end else if (desc_load_i) begin
			desc_off_reg <= desc_value_i;
		end
	end

	// ************************************************************
	// current buffer address and remaining count
	// ************************************************************
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cur_addr_reg <= `RBM_RESET_ADDR;
			rwc_reg      <= `RBM_RESET_ADDR;
		end else if (fetch_done) begin
			cur_addr_reg <= join_ptr;
			rwc_reg      <= {mem_rdata_i[15:0], join_count[15:0]};
		end else if (store_beat) begin
			cur_addr_reg <= cur_addr_reg + data_step;
			rwc_reg      <= rwc_reg - wc_step;
		end
	end

	// ************************************************************
	// fetch command bit
	// ************************************************************
	// cleared when the commanded fetch ends, new command wins
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cmd_reg <= 1'b0;
		end else if (ring_fetch_command_i) begin
			cmd_reg <= 1'b1;
		end else if (fetch_done && by_cmd_reg) begin
			cmd_reg <= 1'b0;
		end
	end

	// ************************************************************
	// overrun flag
	// ************************************************************
	// sticky, set wins over clear
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			overrun_reg <= 1'b0;
		end else if (beat && !fits) begin
			overrun_reg <= 1'b1;
		end else if (overrun_clear_i) begin
			overrun_reg <= 1'b0;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign mem_req_o                = mem_req_reg;
	assign mem_we_o                 = mem_we_reg;
	assign mem_addr_o               = mem_addr_reg;
	assign mem_wdata_o              = mem_wdata_reg;
	assign ring_fetch_command_o     = cmd_reg;
	assign buffer_overrun_flag_o    = overrun_reg;
	assign ring_empty_o             = rrp_reg == ring_write_pointer_i;
	assign ring_read_pointer_o      = rrp_reg;
	assign desc_pointer_o           = desc_off_reg;
	assign current_buffer_address_o = cur_addr_reg;
	assign remaining_word_count_o   = rwc_reg;

	// ************************************************************
	// assertions
	// ************************************************************
	a_cmd_bit_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		fetch_done && by_cmd_reg && !ring_fetch_command_i |=> !ring_fetch_command_o)
		else $error("fetch command bit not cleared");
	a_rrp_wrap_step: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		fetch_done |=> ring_read_pointer_o == $past(rrp_next))
		else $error("ring read pointer step or wrap wrong");
	a_wc_count_down: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		store_beat |=> remaining_word_count_o == $past(rwc_reg) - $past(wc_step))
		else $error("remaining count not decremented");
	a_margin_fetch: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(state_reg == RBM_CHECK) && below_margin |=> (state_reg == RBM_FETCH) && mem_req_o && !mem_we_o)
		else $error("no fetch after margin crossed");
	a_margin_stay: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(state_reg == RBM_CHECK) && !below_margin |=> (state_reg == RBM_IDLE) && $stable(cur_addr_reg))
		else $error("buffer changed without margin crossing");
	a_overrun_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		beat && !fits |=> buffer_overrun_flag_o && $stable(cur_addr_reg))
		else $error("overrun not flagged");
	a_ring_read_only: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(state_reg == RBM_FETCH) && mem_req_o |-> !mem_we_o && mem_addr_o[31:16] == ring_upper_base_i)
		else $error("ring written or wrong base");
	a_ring_load: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		fetch_done |=> current_buffer_address_o == $past(join_ptr)
		&& remaining_word_count_o[31:16] == $past(mem_rdata_i[15:0]))
		else $error("fetched entry not loaded");
	a_desc_advance: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		desc_done |=> (state_reg == RBM_CHECK) && desc_pointer_o == $past(desc_off_reg) + $past(desc_step))
		else $error("descriptor pointer not advanced");

endmodule
`default_nettype wire

//--- testbench/rbm_host_model.sv
// Purpose: host memory model answering the dma port of the buffer manager
// Assumes: one request outstanding, ack after lat_i extra cycles
// Notes:   writes are logged in queues that the bench drains
`timescale 1ns/1ps
`default_nettype none

module rbm_host_model (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic [3:0]  lat_i,
	input  wire logic        mem_req_i,
	input  wire logic        mem_we_i,
	input  wire logic [31:0] mem_addr_i,
	input  wire logic [31:0] mem_wdata_i,
	output logic             mem_ack_o,
	output logic      [31:0] mem_rdata_o
);
	// ************************************************************
	// memory contents and write log
	// ************************************************************
	logic [15:0] mem [logic [31:0]];
	logic [31:0] wr_a [$];
	logic [31:0] wr_d [$];
	logic [3:0]  wait_reg;
	logic [15:0] junk_reg;

	// entry stored as four aligned 16-bit fields, pointer first
	task automatic put_entry(input logic [31:0] a, input logic [31:0] s, input logic [31:0] p, input logic [31:0] c);
		mem[a] = p[15:0];
		mem[a + s] = p[31:16];
		mem[a + 2 * s] = c[15:0];
		mem[a + 3 * s] = c[31:16];
	endtask

	// upper half and idle data always carry a changing junk pattern
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mem_ack_o <= 1'b0;
			wait_reg <= 4'h0;
			junk_reg <= 16'hA5C3;
			mem_rdata_o <= 32'h0000_0000;
		end else begin
			junk_reg <= {junk_reg[14:0], junk_reg[15] ^ junk_reg[13]};
			mem_rdata_o <= {junk_reg, ~junk_reg};
			mem_ack_o <= 1'b0;
			if (mem_ack_o && mem_req_i && mem_we_i) begin
				wr_a.push_back(mem_addr_i);
				wr_d.push_back(mem_wdata_i);
			end
			if (mem_req_i && !mem_ack_o) begin
				wait_reg <= wait_reg + 4'h1;
				if (wait_reg >= lat_i) begin
					mem_ack_o <= 1'b1;
					wait_reg <= 4'h0;
					if (!mem_we_i && mem.exists(mem_addr_i)) begin
						mem_rdata_o <= {junk_reg, mem[mem_addr_i]};
					end
				end
			end
		end
	end
endmodule

`default_nettype wire

//--- testbench/rbm_rx_buffer_manager_bench.sv
// Purpose: self-checking bench of the receive buffer manager
// Assumes: host model answers memory requests
// Notes:   16-bit run first, then a reset into 32-bit mode
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; $display("BAD t=%0t got %h exp %h", $time, got, exp); end end

module rbm_rx_buffer_manager_bench;
	// ************************************************************
	// signals and instances
	// ************************************************************
	logic ref_clk_i, rst_b_i, mode32_i, receiver_enable_i, ring_fetch_command_i, ring_read_load_i, desc_load_i;
	logic overrun_clear_i, pkt_valid_i, pkt_last_i, match_phys_i, match_mcast_i, match_bcast_i, mem_ack_i;
	logic [15:0] ring_upper_base_i, ring_start_pointer_i, ring_end_pointer_i, ring_write_pointer_i;
	logic [15:0] ring_read_value_i, desc_upper_base_i, desc_value_i, end_margin_count_i, pkt_status_i, pkt_byte_count_i;
	logic [31:0] pkt_data_i, mem_rdata_i, mem_addr_o, mem_wdata_o, current_buffer_address_o, remaining_word_count_o;
	logic pkt_ready_o, mem_req_o, mem_we_o, ring_fetch_command_o, buffer_overrun_flag_o, ring_empty_o;
	logic [15:0] ring_read_pointer_o, desc_pointer_o;
	logic [3:0]  lat_i;
	int          checks, mismatches;

	rbm_rx_buffer_manager DUT (.ref_clk_i, .rst_b_i, .mode32_i, .receiver_enable_i, .ring_fetch_command_i,
		.ring_upper_base_i, .ring_start_pointer_i, .ring_end_pointer_i, .ring_write_pointer_i, .ring_read_load_i,
		.ring_read_value_i, .desc_upper_base_i, .desc_load_i, .desc_value_i, .end_margin_count_i, .overrun_clear_i,
		.pkt_valid_i, .pkt_data_i, .pkt_last_i, .match_phys_i, .match_mcast_i, .match_bcast_i, .pkt_status_i,
		.pkt_byte_count_i, .pkt_ready_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i,
		.ring_fetch_command_o, .buffer_overrun_flag_o, .ring_empty_o, .ring_read_pointer_o, .desc_pointer_o,
		.current_buffer_address_o, .remaining_word_count_o);

	rbm_host_model host (.ref_clk_i, .rst_b_i, .lat_i, .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
		.mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

	// free-running clock
	always #4 ref_clk_i = ~ref_clk_i;

	// ************************************************************
	// access tasks
	// ************************************************************
	task automatic step();
		@(posedge ref_clk_i);
		#1;
	endtask

	// waits until memory port and command bit stay quiet for 8 cycles
	task automatic wait_idle();
		int quiet;
		int n;
		quiet = 0;
		for (n = 0; n < 400 && quiet < 8; n++) begin
			@(negedge ref_clk_i);
			quiet = (mem_req_o || ring_fetch_command_o) ? 0 : quiet + 1;
		end
		`CHK(quiet, 8)
	endtask

	task automatic load_ptrs(input logic [15:0] r, input logic [15:0] d);
		step();
		{ring_read_load_i, desc_load_i, ring_read_value_i, desc_value_i} = {2'b11, r, d};
		step();
		{ring_read_load_i, desc_load_i} = 2'b00;
	endtask

	task automatic fetch();
		step();
		ring_fetch_command_i = 1'b1;
		step();
		ring_fetch_command_i = 1'b0;
		wait_idle();
	endtask

	// sends n beats, each held until the device takes it
	task automatic send_pkt(input int n, input logic [31:0] d, input logic [2:0] m);
		int i;
		int k;
		step();
		{match_phys_i, match_mcast_i, match_bcast_i} = m;
		pkt_status_i = 16'h8000 | 16'(n);
		pkt_byte_count_i = mode32_i ? 16'(n * 4) : 16'(n * 2);
		for (i = 0; i < n; i++) begin
			{pkt_valid_i, pkt_last_i, pkt_data_i} = {1'b1, i == n - 1, d + 32'(i)};
			k = 0;
			@(negedge ref_clk_i);
			while (!pkt_ready_o && k < 100) begin
				@(negedge ref_clk_i);
				k++;
			end
			step();
		end
		{pkt_valid_i, pkt_last_i, match_phys_i, match_mcast_i, match_bcast_i} = 5'h00;
		wait_idle();
	endtask

	task automatic exp_wr(input logic [31:0] a, input logic [31:0] d);
		if (host.wr_a.size() == 0) begin
			mismatches++;
			$display("BAD t=%0t missing write to %h", $time, a);
		end else begin
			`CHK(host.wr_a.pop_front(), a)
			`CHK(host.wr_d.pop_front(), d)
		end
	endtask

	task automatic exp_desc(input logic [31:0] a, input logic [31:0] s, input logic [15:0] st, input logic [15:0] bc,
			input logic [31:0] p);
		exp_wr(a, {16'h0000, st});
		exp_wr(a + s, {16'h0000, bc});
		exp_wr(a + 2 * s, {16'h0000, p[15:0]});
		exp_wr(a + 3 * s, {16'h0000, p[31:16]});
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ************************************************************
	// watchdog and test sequence
	// ************************************************************
	initial begin
		#40000;
		mismatches++;
		report_and_stop();
	end

	initial begin
		{ref_clk_i, rst_b_i, mode32_i, receiver_enable_i, ring_fetch_command_i, ring_read_load_i, desc_load_i} = 7'h00;
		{overrun_clear_i, pkt_valid_i, pkt_last_i, match_phys_i, match_mcast_i, match_bcast_i} = 6'h00;
		{ring_read_value_i, desc_value_i, pkt_status_i, pkt_byte_count_i, pkt_data_i} = 96'h0;
		{lat_i, checks, mismatches} = '0;
		// memory and pointers prepared before the receiver is enabled
		host.put_entry(32'h0001_0100, 32'h2, 32'h0002_0000, 32'h6);
		host.put_entry(32'h0001_0108, 32'h2, 32'h0003_0000, 32'h2);
		{ring_upper_base_i, ring_start_pointer_i, ring_end_pointer_i} = {16'h0001, 16'h0100, 16'h0110};
		{ring_write_pointer_i, desc_upper_base_i, end_margin_count_i} = {16'h0108, 16'h0005, 16'h0003};
		repeat (5) @(posedge ref_clk_i);
		#1 rst_b_i = 1'b1;
		load_ptrs(16'h0100, 16'h0300);
		`CHK(ring_empty_o, 1'b0)
		fetch();
		`CHK(current_buffer_address_o, 32'h0002_0000)
		`CHK(remaining_word_count_o, 32'h0000_0006)
		`CHK(ring_read_pointer_o, 16'h0108)
		`CHK(ring_fetch_command_o, 1'b0)
		`CHK(ring_empty_o, 1'b1)
		`CHK(host.wr_a.size(), 0)
		receiver_enable_i = 1'b1;
		send_pkt(2, 32'hBEEF_1230, 3'b100);
		exp_wr(32'h0002_0000, 32'h0000_1230);
		exp_wr(32'h0002_0002, 32'h0000_1231);
		exp_desc(32'h0005_0300, 32'h2, 16'h8002, 16'h0004, 32'h0002_0000);
		`CHK(desc_pointer_o, 16'h030C)
		`CHK(remaining_word_count_o, 32'h0000_0004)
		`CHK(current_buffer_address_o, 32'h0002_0004)
		send_pkt(3, 32'h0000_0000, 3'b000);
		`CHK(host.wr_a.size(), 0)
		lat_i = 4'h3;
		send_pkt(2, 32'h0000_7770, 3'b010);
		exp_wr(32'h0002_0004, 32'h0000_7770);
		exp_wr(32'h0002_0006, 32'h0000_7771);
		exp_desc(32'h0005_030C, 32'h2, 16'h8002, 16'h0004, 32'h0002_0004);
		`CHK(current_buffer_address_o, 32'h0003_0000)
		`CHK(remaining_word_count_o, 32'h0000_0002)
		`CHK(ring_read_pointer_o, 16'h0100)
		lat_i = 4'h0;
		send_pkt(3, 32'h0000_4440, 3'b001);
		exp_wr(32'h0003_0000, 32'h0000_4440);
		exp_wr(32'h0003_0002, 32'h0000_4441);
		exp_desc(32'h0005_0318, 32'h2, 16'h8003, 16'h0006, 32'h0003_0000);
		`CHK(host.wr_a.size(), 0)
		`CHK(buffer_overrun_flag_o, 1'b1)
		step();
		overrun_clear_i = 1'b1;
		step();
		overrun_clear_i = 1'b0;
		`CHK(buffer_overrun_flag_o, 1'b0)
		// second run in 32-bit mode, margin kept even
		rst_b_i = 1'b0;
		mode32_i = 1'b1;
		host.put_entry(32'h0001_0200, 32'h4, 32'h0004_0000, 32'h10);
		{ring_start_pointer_i, ring_end_pointer_i, ring_write_pointer_i} = {16'h0200, 16'h0220, 16'h0210};
		end_margin_count_i = 16'h0004;
		repeat (5) step();
		rst_b_i = 1'b1;
		load_ptrs(16'h0200, 16'h0400);
		fetch();
		`CHK(current_buffer_address_o, 32'h0004_0000)
		`CHK(remaining_word_count_o, 32'h0000_0010)
		`CHK(ring_read_pointer_o, 16'h0210)
		send_pkt(1, 32'hDEAD_BEEF, 3'b001);
		exp_wr(32'h0004_0000, 32'hDEAD_BEEF);
		exp_desc(32'h0005_0400, 32'h4, 16'h8001, 16'h0004, 32'h0004_0000);
		`CHK(remaining_word_count_o, 32'h0000_000E)
		`CHK(desc_pointer_o, 16'h0418)
		`CHK(current_buffer_address_o, 32'h0004_0004)
		report_and_stop();
	end
endmodule

`default_nettype wire
